// ===== bench/bdp_decode_properties.sv
`timescale 1ns/1ps
`default_nettype none
module bdp_decode_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr
);
  logic ok_addr;
  // control words plus the register window; anything else must error
  assign ok_addr = paddr[1:0] == 2'b00 && (paddr <= 12'h00c || paddr[11:6] == 6'h01);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready held too long");
  property p_cause; pready |-> $past(psel && penable); endproperty
  a_cause: assert property (p_cause) else $error("pready without access");
  property p_bound; psel && penable && !pready |-> ##[1:6] pready; endproperty
  a_bound: assert property (p_bound) else $error("answer too late");
  property p_err; pready |-> pslverr == !ok_addr; endproperty
  a_err: assert property (p_err) else $error("wrong error answer");
  property p_quiet; !pready |-> prdata == 32'h0 && !pslverr; endproperty
  a_quiet: assert property (p_quiet) else $error("outputs outside answer");
  // a taken branch keeps the bus stalled for its fetches
  property p_branch; pready && pwrite && paddr == 12'h000 && pwdata[31:25] == 7'h75 |=> !pready [*4]; endproperty
  a_branch: assert property (p_branch) else $error("branch finished early");
  property p_flagw; pready && !pwrite && paddr == 12'h008 |-> prdata[31:4] == 28'h0; endproperty
  a_flagw: assert property (p_flagw) else $error("flags word too wide");
  property p_idle; pready && !pwrite && paddr == 12'h00c |-> !prdata[0]; endproperty
  a_idle: assert property (p_idle) else $error("busy seen on answer");
endmodule
`default_nettype wire

// ===== bench/branch_and_dataproc_decode_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "bdp_map.svh"
module branch_and_dataproc_decode_tb;
  import bdp_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, q;
  int fail_count = 0, total_checks = 0;
  bdp_decode dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
  always #2 pclk = ~pclk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready sampled high
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  function automatic logic holds(input logic [3:0] c, input logic [3:0] f);
    logic r;
    case (c[3:1])
      3'd0: r = f[2];
      3'd1: r = f[1];
      3'd2: r = f[3];
      3'd3: r = f[0];
      3'd4: r = f[1] && !f[2];
      3'd5: r = f[3] == f[0];
      3'd6: r = !f[2] && f[3] == f[0];
      default: r = 1'b1;
    endcase
    return c == 4'hf ? 1'b0 : r ^ (c[0] && c != 4'he);
  endfunction
  // carry in is taken as set, matching the flags each case starts from
  function automatic logic [31:0] alu(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
    case (op)
      4'h0, 4'h8: return a & b;
      4'h1, 4'h9: return a ^ b;
      4'h2, 4'h6, 4'ha: return a - b;
      4'h3, 4'h7: return b - a;
      4'h4, 4'hb: return a + b;
      4'h5: return a + b + 32'h1;
      4'hc: return a | b;
      4'hd: return b;
      4'he: return a & ~b;
      default: return ~b;
    endcase
  endfunction
  task automatic br(input logic [31:0] pc, input logic [31:0] ins, input logic [3:0] f,
    input logic [31:0] tgt, input logic [31:0] lk);
    wr(`BDP_OFF_FLAGS, {28'h0, f});
    wr(`BDP_OFF_PC, pc);
    wr(12'h078, 32'h5a5a_0000);
    wr(`BDP_OFF_INSTR, ins);
    rdc(`BDP_OFF_PC, tgt);
    rdc(12'h078, lk);
    rdc(`BDP_OFF_FLAGS, {28'h0, f});
  endtask
  task automatic dp(input logic [31:0] ins, input logic [3:0] f, input logic [31:0] r1, input logic [3:0] fo);
    wr(`BDP_OFF_FLAGS, {28'h0, f});
    wr(12'h044, 32'hdead_beef);
    wr(`BDP_OFF_INSTR, ins);
    rdc(12'h044, r1);
    rdc(`BDP_OFF_FLAGS, {28'h0, fo});
  endtask
  task automatic t_reset;
    rdc(`BDP_OFF_PC, `BDP_PC_RESET);
    rdc(`BDP_OFF_FLAGS, 32'h0);
    rdc(12'h078, `BDP_REG_RESET);
    xfer(1'b0, 12'h100, 32'h0);
    chk({31'h0, e}, 32'h1);
    xfer(1'b0, 12'h042, 32'h0);
    chk({31'h0, e}, 32'h1);
    wr(`BDP_OFF_INSTR, 32'he600_0000);
    rdc(`BDP_OFF_STATUS, 32'h8);
    rdc(`BDP_OFF_PC, 32'h4);
    $display("reset test done");
  endtask
  task automatic t_branch;
    br(32'h100, 32'hea00_0002, 4'h0, 32'h110, 32'h5a5a_0000);
    rdc(`BDP_OFF_STATUS, 32'h2);
    br(32'h200, 32'hebff_fffe, 4'h0, 32'h200, 32'h204);
    br(32'h300_0000, 32'heb80_0000, 4'h0, 32'h100_0008, 32'h300_0004);
    $display("branch test done");
  endtask
  // every condition against every flag setting
  task automatic t_cond;
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        if (holds(c[3:0], f[3:0]))
          br(32'h400, {c[3:0], 28'hb00_0001}, f[3:0], 32'h40c, 32'h404);
        else
          br(32'h400, {c[3:0], 28'hb00_0001}, f[3:0], 32'h404, 32'h5a5a_0000);
      end
    end
    $display("condition test done");
  endtask
  task automatic t_dp;
    logic [31:0] r;
    logic ar;
    wr(12'h048, 32'h5);
    wr(12'h04c, 32'h3);
    for (int op = 0; op < 16; op++) begin
      r = alu(op[3:0], 32'h5, 32'h3);
      ar = (op >= 2 && op <= 7) || op == 10 || op == 11;
      dp({4'he, 3'b000, op[3:0], 9'h121, 12'h003}, 4'h2, op[3:2] == 2'b10 ? 32'hdead_beef : r,
        {r[31], r == 32'h0, ar ? (op == 2 || op == 6 || op == 10) : 1'b1, 1'b0});
    end
    dp(32'he082_1003, 4'h5, 32'h8, 4'h5);
    dp(32'he3a0_14ff, 4'h0, 32'hff00_0000, 4'h0);
    dp(32'h03a0_14ff, 4'h0, 32'hdead_beef, 4'h0);
    rdc(`BDP_OFF_STATUS, 32'h4);
    // shift amount taken from a register, r3 << r2
    dp(32'he1a0_1213, 4'h0, 32'h60, 4'h0);
    rdc(`BDP_OFF_STATUS, 32'h2);
    wr(`BDP_OFF_PC, 32'h40);
    dp(32'he08f_1003, 4'h0, 32'h4b, 4'h0);
    $display("data test done");
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_branch();
    t_cond();
    t_dp();
    close_out();
  end
  // the whole run needs roughly 8k cycles; give it nearly four times that
  initial begin
    #120000;
    fail_count++;
    close_out();
  end
endmodule
bind bdp_decode bdp_decode_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr));
`default_nettype wire

// ===== hdl/bdp_decode.sv
// Notes on behaviour
// - execute only when condition holds on flags
// - failed branch moves pc on one word, leaves link alone
// - bit 24 picks branch or branch_with_link
// - target adds shifted sign-extended offset to pc
// - pc used is instruction address plus 8
// - branch_with_link saves following address in link_register
// - no status save; plain branch keeps link_register
// - both branch forms take three fetch cycles
// - failed data op writes nothing, flags kept
// - first operand from first_operand_reg
// - immediate bit picks shifted register or rotated imm
// - flag-update bit gates flag writes
// - test and compare forms never write destination
// - opcode selects one of sixteen operations
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "bdp_map.svh"
module bdp_decode
  import bdp_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr
);
  // condition check against the status flags
  function automatic logic cond_pass(input logic [3:0] cond, input bdp_flags_t f);
    case (bdp_cond_t'(cond))
      bdp_c_eq: cond_pass = f.z;
      bdp_c_ne: cond_pass = !f.z;
      bdp_c_cs: cond_pass = f.c;
      bdp_c_cc: cond_pass = !f.c;
      bdp_c_mi: cond_pass = f.n;
      bdp_c_pl: cond_pass = !f.n;
      bdp_c_vs: cond_pass = f.v;
      bdp_c_vc: cond_pass = !f.v;
      bdp_c_hi: cond_pass = f.c && !f.z;
      bdp_c_ls: cond_pass = !f.c || f.z;
      bdp_c_ge: cond_pass = f.n == f.v;
      bdp_c_lt: cond_pass = f.n != f.v;
      bdp_c_gt: cond_pass = !f.z && (f.n == f.v);
      bdp_c_le: cond_pass = f.z || (f.n != f.v);
      bdp_c_al: cond_pass = 1'b1;
      default: cond_pass = 1'b0; // never code: treated as a no-op
    endcase
  endfunction

  // 32-bit add with carry in, carry and overflow out
  function automatic bdp_alu_t add3(input logic [31:0] x, input logic [31:0] y, input logic cin);
    logic [32:0] s;
    s = {1'b0, x} + {1'b0, y} + {32'h0, cin};
    add3.value = s[31:0];
    add3.c = s[32];
    add3.v = (x[31] == y[31]) && (s[31] != x[31]);
  endfunction

  // barrel shifter; a zero amount has special meanings in the immediate form
  function automatic bdp_alu_t shifter(input logic [31:0] val, input bdp_shift_t kind,
                                       input logic [7:0] amt, input logic cin, input logic by_reg);
    logic [32:0] w;
    logic [63:0] rr;
    logic [7:0] a;
    w = 33'h0;
    rr = 64'h0;
    a = amt;
    shifter.v = 1'b0;
    shifter.value = val;
    shifter.c = cin;
    if (a == 8'h00 && !by_reg && kind == bdp_sh_ror) begin
      shifter.value = {cin, val[31:1]}; // rotate through carry
      shifter.c = val[0];
    end else if (a != 8'h00 || (!by_reg && kind != bdp_sh_lsl)) begin
      if (a == 8'h00) begin
        a = 8'h20; // immediate right shift by zero means 32
      end
      case (kind)
        bdp_sh_lsl: begin
          w = {1'b0, val} << a;
          shifter.value = w[31:0];
          shifter.c = w[32];
        end
        bdp_sh_lsr: begin
          w = {val, 1'b0} >> a;
          shifter.value = w[32:1];
          shifter.c = w[0];
        end
        bdp_sh_asr: begin
          w = $unsigned($signed({val, 1'b0}) >>> a);
          shifter.value = w[32:1];
          shifter.c = w[0];
        end
        default: begin
          rr = {val, val} >> a[4:0];
          shifter.value = rr[31:0];
          shifter.c = rr[31];
        end
      endcase
    end
  endfunction

  bdp_state_t state, next_state;
  logic [31:0] instr, next_instr;
  logic [31:0] pc, next_pc;
  logic [31:0] target, next_target;
  logic [1:0] cnt, next_cnt;
  bdp_flags_t flags, next_flags;
  bdp_status_t status, next_status;
  logic [31:0] regs [0:14];
  logic [31:0] next_regs [0:14];
  logic next_pready, next_pslverr;
  logic [31:0] next_prdata;

  // decoded views of the held instruction
  bdp_dp_t dp;
  bdp_branch_t br;
  bdp_shreg_t shr;
  bdp_rotimm_t rimm;
  assign dp = bdp_dp_t'(instr);
  assign br = bdp_branch_t'(instr);
  assign shr = bdp_shreg_t'(dp.op2);
  assign rimm = bdp_rotimm_t'(dp.op2);

  // operand fetch; pc reads as the prefetched value
  logic [31:0] op_a, op_m, op_s;
  always_comb begin
    op_a = (dp.first_operand_reg == `BDP_PC_IDX) ? pc + `BDP_PC_AHEAD : regs[dp.first_operand_reg];
    op_m = (shr.second_operand_reg == `BDP_PC_IDX) ? pc + `BDP_PC_AHEAD : regs[shr.second_operand_reg];
    op_s = (shr.amount[4:1] == `BDP_PC_IDX) ? pc + `BDP_PC_AHEAD : regs[shr.amount[4:1]];
  end

  // second operand and alu
  bdp_alu_t op2, res;
  logic logical, writes_rd;
  always_comb begin
    if (dp.imm) begin
      op2.value = {24'h0, rimm.imm8} >> {rimm.rot, 1'b0} | {24'h0, rimm.imm8} << (6'h20 - {rimm.rot, 1'b0});
      op2.c = (rimm.rot == 4'h0) ? flags.c : op2.value[31];
      op2.v = 1'b0;
    end else begin
      op2 = shifter(op_m, bdp_shift_t'(shr.kind), shr.by_reg ? op_s[7:0] : {3'h0, shr.amount},
                    flags.c, shr.by_reg);
    end
    logical = 1'b1;
    res = '{c: op2.c, v: flags.v, value: 32'h0};
    case (bdp_opcode_t'(dp.opcode))
      bdp_op_and, bdp_test_and_op: res.value = op_a & op2.value;
      bdp_op_eor, bdp_test_equiv_op: res.value = op_a ^ op2.value;
      bdp_op_orr: res.value = op_a | op2.value;
      bdp_op_mov: res.value = op2.value;
      bdp_op_bic: res.value = op_a & ~op2.value;
      bdp_op_mvn: res.value = ~op2.value;
      bdp_op_sub, bdp_compare_op: begin
        res = add3(op_a, ~op2.value, 1'b1);
        logical = 1'b0;
      end
      bdp_op_rsb: begin
        res = add3(op2.value, ~op_a, 1'b1);
        logical = 1'b0;
      end
      bdp_op_add, bdp_compare_negative_op: begin
        res = add3(op_a, op2.value, 1'b0);
        logical = 1'b0;
      end
      bdp_op_adc: begin
        res = add3(op_a, op2.value, flags.c);
        logical = 1'b0;
      end
      bdp_op_sbc: begin
        res = add3(op_a, ~op2.value, flags.c);
        logical = 1'b0;
      end
      default: begin
        res = add3(op2.value, ~op_a, flags.c); // reverse subtract with carry
        logical = 1'b0;
      end
    endcase
    writes_rd = dp.opcode[3:2] != 2'b10;
  end

  // apb decode: when idle, a request is answered one cycle after its access phase opens
  logic access, hit_regs, mapped;
  logic [3:0] ridx;
  always_comb begin
    access = psel && penable && !pready;
    hit_regs = paddr[11:6] == `BDP_REGS_PAGE && paddr[1:0] == 2'b00; // no byte lanes, so unaligned errors
    ridx = paddr[5:2];
    mapped = hit_regs || paddr == `BDP_OFF_INSTR || paddr == `BDP_OFF_PC ||
             paddr == `BDP_OFF_FLAGS || paddr == `BDP_OFF_STATUS;
  end

  // next-state logic for execution and the register file
  always_comb begin
    next_state = state;
    next_instr = instr;
    next_pc = pc;
    next_target = target;
    next_cnt = cnt;
    next_flags = flags;
    next_status = status;
    next_regs = regs;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = 32'h0;
    // bus requests stall while an instruction is in flight
    if (access && state == bdp_idle) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      if (hit_regs) begin
        next_prdata = (ridx == `BDP_PC_IDX) ? pc : regs[ridx];
      end else if (paddr == `BDP_OFF_INSTR) begin
        next_prdata = instr;
      end else if (paddr == `BDP_OFF_PC) begin
        next_prdata = pc;
      end else if (paddr == `BDP_OFF_FLAGS) begin
        next_prdata = {28'h0, flags};
      end else if (paddr == `BDP_OFF_STATUS) begin
        next_prdata = {28'h0, status};
      end
    end
    // writes land on the edge where the master samples pready
    if (psel && penable && pready && pwrite && !pslverr) begin
      if (hit_regs && ridx == `BDP_PC_IDX) begin
        next_pc = pwdata;
      end else if (hit_regs) begin
        next_regs[ridx] = pwdata;
      end else if (paddr == `BDP_OFF_INSTR) begin
        next_instr = pwdata;
        next_state = bdp_exec;
        next_status.busy = 1'b1;
      end else if (paddr == `BDP_OFF_PC) begin
        next_pc = pwdata;
      end else if (paddr == `BDP_OFF_FLAGS) begin
        next_flags = bdp_flags_t'(pwdata[3:0]);
      end
    end
    case (state)
      bdp_exec: begin
        next_status = '{unsupported: 1'b0, skipped: 1'b0, executed: 1'b0, busy: 1'b1};
        next_state = bdp_idle;
        next_pc = pc + `BDP_WORD;
        if (!cond_pass(dp.cond, flags)) begin
          next_status = '{unsupported: 1'b0, skipped: 1'b1, executed: 1'b0, busy: 1'b0};
        end else if (br.cls == `BDP_CLASS_BRANCH) begin
          next_target = pc + `BDP_PC_AHEAD + {{6{br.offset[23]}}, br.offset, 2'b00};
          if (br.link) begin
            next_regs[`BDP_LINK_IDX] = pc + `BDP_WORD;
          end
          next_pc = pc;
          next_cnt = `BDP_BRANCH_FETCHES - 2'h1;
          next_state = bdp_fetch;
        end else if (dp.cls == `BDP_CLASS_DP) begin
          next_status = '{unsupported: 1'b0, skipped: 1'b0, executed: 1'b1, busy: 1'b0};
          if (writes_rd && dp.rd == `BDP_PC_IDX) begin
            next_pc = res.value;
          end else if (writes_rd) begin
            next_regs[dp.rd] = res.value;
          end
          if (dp.s && dp.rd != `BDP_PC_IDX) begin
            next_flags.n = res.value[31];
            next_flags.z = res.value == 32'h0;
            next_flags.c = res.c;
            next_flags.v = logical ? flags.v : res.v;
          end
        end else begin
          next_status = '{unsupported: 1'b1, skipped: 1'b0, executed: 1'b0, busy: 1'b0};
        end
      end
      bdp_fetch: begin
        // refill after a taken branch; pc moves on the last fetch
        next_cnt = cnt - 2'h1;
        if (cnt == 2'h1) begin
          next_pc = target;
          next_state = bdp_idle;
          next_status = '{unsupported: 1'b0, skipped: 1'b0, executed: 1'b1, busy: 1'b0};
        end
      end
      default: begin
        next_cnt = 2'h0;
      end
    endcase
  end

  // state registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= bdp_idle;
      instr <= 32'h0;
      pc <= `BDP_PC_RESET;
      target <= `BDP_PC_RESET;
      cnt <= 2'h0;
      flags <= `BDP_FLAGS_RESET;
      status <= 4'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      for (int i = 0; i < 15; i++) begin
        regs[i] <= `BDP_REG_RESET;
      end
    end else begin
      state <= next_state;
      instr <= next_instr;
      pc <= next_pc;
      target <= next_target;
      cnt <= next_cnt;
      flags <= next_flags;
      status <= next_status;
      pready <= next_pready;
      pslverr <= next_pslverr;
      prdata <= next_prdata;
      regs <= next_regs;
    end
  end
endmodule
`default_nettype wire

// ===== hdl/bdp_map.svh
`ifndef BDP_MAP_SVH
`define BDP_MAP_SVH
// register offsets on the apb bus (byte addresses)
`define BDP_OFF_INSTR 12'h000
`define BDP_OFF_PC 12'h004
`define BDP_OFF_FLAGS 12'h008
`define BDP_OFF_STATUS 12'h00c
// register file window, one word per register index
`define BDP_REGS_PAGE 6'h01
// reset values
`define BDP_PC_RESET 32'h0000_0000
`define BDP_REG_RESET 32'h0000_0000
`define BDP_FLAGS_RESET 4'h0
// pipeline figures
`define BDP_PC_AHEAD 32'h0000_0008
`define BDP_WORD 32'h0000_0004
`define BDP_BRANCH_FETCHES 2'h3
// register indices and class patterns
`define BDP_LINK_IDX 4'he
`define BDP_PC_IDX 4'hf
`define BDP_CLASS_BRANCH 3'b101
`define BDP_CLASS_DP 2'b00
`endif

// ===== hdl/bdp_pkg.sv
`default_nettype none
package bdp_pkg;
  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
  } bdp_flags_t;

  typedef struct packed {
    logic unsupported;
    logic skipped;
    logic executed;
    logic busy;
  } bdp_status_t;

  typedef struct packed {
    logic [3:0] cond;
    logic [2:0] cls;
    logic link;
    logic [23:0] offset;
  } bdp_branch_t;

  typedef struct packed {
    logic [3:0] cond;
    logic [1:0] cls;
    logic imm;
    logic [3:0] opcode;
    logic s;
    logic [3:0] first_operand_reg;
    logic [3:0] rd;
    logic [11:0] op2;
  } bdp_dp_t;

  typedef struct packed {
    logic [4:0] amount;
    logic [1:0] kind;
    logic by_reg;
    logic [3:0] second_operand_reg;
  } bdp_shreg_t;

  typedef struct packed {
    logic [3:0] rot;
    logic [7:0] imm8;
  } bdp_rotimm_t;

  typedef struct packed {
    logic c;
    logic v;
    logic [31:0] value;
  } bdp_alu_t;

  typedef enum logic [1:0] {
    bdp_sh_lsl = 2'b00,
    bdp_sh_lsr = 2'b01,
    bdp_sh_asr = 2'b10,
    bdp_sh_ror = 2'b11
  } bdp_shift_t;

  typedef enum logic [3:0] {
    bdp_op_and = 4'b0000,
    bdp_op_eor = 4'b0001,
    bdp_op_sub = 4'b0010,
    bdp_op_rsb = 4'b0011,
    bdp_op_add = 4'b0100,
    bdp_op_adc = 4'b0101,
    bdp_op_sbc = 4'b0110,
    bdp_op_rsc = 4'b0111,
    bdp_test_and_op = 4'b1000,
    bdp_test_equiv_op = 4'b1001,
    bdp_compare_op = 4'b1010,
    bdp_compare_negative_op = 4'b1011,
    bdp_op_orr = 4'b1100,
    bdp_op_mov = 4'b1101,
    bdp_op_bic = 4'b1110,
    bdp_op_mvn = 4'b1111
  } bdp_opcode_t;

  typedef enum logic [3:0] {
    bdp_c_eq = 4'h0, bdp_c_ne = 4'h1, bdp_c_cs = 4'h2, bdp_c_cc = 4'h3,
    bdp_c_mi = 4'h4, bdp_c_pl = 4'h5, bdp_c_vs = 4'h6, bdp_c_vc = 4'h7,
    bdp_c_hi = 4'h8, bdp_c_ls = 4'h9, bdp_c_ge = 4'ha, bdp_c_lt = 4'hb,
    bdp_c_gt = 4'hc, bdp_c_le = 4'hd, bdp_c_al = 4'he, bdp_c_nv = 4'hf
  } bdp_cond_t;

  typedef enum logic [1:0] {
    bdp_idle = 2'b00,
    bdp_exec = 2'b01,
    bdp_fetch = 2'b10
  } bdp_state_t;
endpackage
`default_nettype wire
